// ===== core/eeprom_host_pkg.sv
// Constants and types for the parallel nonvolatile memory host controller
package eeprom_host_pkg;
  localparam int CLK_NS       = 50;
  localparam int CNT_W        = 18;
  localparam int ADDR_W       = 13;
  localparam int DATA_W       = 8;
  localparam int PAGE_MSB     = 12;
  localparam int PAGE_LSB     = 6;
  localparam int BUSY_BIT     = 7;
  localparam int TOGGLE_BIT   = 6;
  localparam int SYNC_STAGES  = 2;
  localparam int LOCK_MAX     = 6;
  localparam int LOCK_ON_LEN  = 3;
  localparam int LOCK_OFF_LEN = 6;
  // Times as printed, in their own units
  localparam int ACC_NS       = 70;
  localparam int WP_NS        = 100;
  localparam int OEHP_NS      = 150;
  localparam int LOAD_WIN_US  = 150;
  localparam int PROG_TIME_MS = 2;
  localparam int ERASE_SH_US  = 5;
  localparam int ERASE_W_MS   = 10;
  // Cycle counts: least times round up, longest round down
  localparam logic [CNT_W-1:0] ACC_CYC      = CNT_W'((ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] WP_CYC       = CNT_W'((WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] OEHP_CYC     = CNT_W'((OEHP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] READ_CYC     = ACC_CYC + CNT_W'(SYNC_STAGES + 1);
  localparam logic [11:0]      LOAD_CYC     = 12'((LOAD_WIN_US * 1000) / CLK_NS);
  // Margin so the strobe itself still lands inside the window
  localparam logic [11:0]      LOAD_GUARD   = 12'((LOAD_WIN_US * 1000 * 3) / (CLK_NS * 4));
  localparam logic [CNT_W-1:0] PROG_CYC     = CNT_W'((PROG_TIME_MS * 1000000) / CLK_NS);
  localparam logic [CNT_W-1:0] POLL_LIMIT   = CNT_W'((2 * PROG_TIME_MS * 1000000) / CLK_NS);
  localparam logic [CNT_W-1:0] ERASE_SH_CYC = CNT_W'((ERASE_SH_US * 1000 + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] ERASE_W_CYC  = CNT_W'((ERASE_W_MS * 1000000 + CLK_NS - 1) / CLK_NS);
  // Command tables: values arbitrary, replace with the real sequences
  localparam logic [LOCK_MAX-1:0][ADDR_W-1:0] LOCK_ON_ADDR  =
    {13'h0000, 13'h0000, 13'h0000, 13'h0303, 13'h0202, 13'h0101};
  localparam logic [LOCK_MAX-1:0][DATA_W-1:0] LOCK_ON_DATA  =
    {8'h00, 8'h00, 8'h00, 8'h33, 8'h22, 8'h11};
  localparam logic [LOCK_MAX-1:0][ADDR_W-1:0] LOCK_OFF_ADDR =
    {13'h0606, 13'h0505, 13'h0404, 13'h0303, 13'h0202, 13'h0101};
  localparam logic [LOCK_MAX-1:0][DATA_W-1:0] LOCK_OFF_DATA =
    {8'h66, 8'h55, 8'h44, 8'h33, 8'h22, 8'h11};

  typedef enum logic [2:0] {
    OP_READ     = 3'h0,
    OP_WRITE    = 3'h1,
    OP_LOCK_ON  = 3'h2,
    OP_LOCK_OFF = 3'h3,
    OP_ERASE    = 3'h4
  } op_t;

  typedef enum logic [3:0] {
    S_IDLE     = 4'h0,
    S_STRB_LO  = 4'h1,
    S_STRB_HI  = 4'h2,
    S_LOAD     = 4'h3,
    S_EXIT_LO  = 4'h4,
    S_EXIT_OE  = 4'h5,
    S_RD_WAIT  = 4'h6,
    S_RD_REST  = 4'h7,
    S_POLL_CHK = 4'h8,
    S_ER_SETUP = 4'h9,
    S_ER_PULSE = 4'ha,
    S_ER_HOLD  = 4'hb
  } state_t;
endpackage : eeprom_host_pkg

// ===== core/pin_sync.sv
// Two-stage synchroniser for the data pins
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  // Pins in, synchronised out
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_st_t;

  sync_st_t q;
  sync_st_t d;

  always_comb begin
    d    = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.s2;
endmodule : pin_sync

// ===== core/eeprom_host.sv
// Host controller driving a byte-wide page-write nonvolatile memory
`timescale 1ns/1ns
module eeprom_host
  import eeprom_host_pkg::*;
#(
  parameter logic [eeprom_host_pkg::CNT_W-1:0] POLL_LIMIT_P = eeprom_host_pkg::POLL_LIMIT,
  parameter logic [eeprom_host_pkg::CNT_W-1:0] ERASE_W_P    = eeprom_host_pkg::ERASE_W_CYC,
  parameter logic [eeprom_host_pkg::LOCK_MAX-1:0][eeprom_host_pkg::ADDR_W-1:0]
    LOCK_ON_ADDR_P  = eeprom_host_pkg::LOCK_ON_ADDR,
  parameter logic [eeprom_host_pkg::LOCK_MAX-1:0][eeprom_host_pkg::DATA_W-1:0]
    LOCK_ON_DATA_P  = eeprom_host_pkg::LOCK_ON_DATA,
  parameter logic [eeprom_host_pkg::LOCK_MAX-1:0][eeprom_host_pkg::ADDR_W-1:0]
    LOCK_OFF_ADDR_P = eeprom_host_pkg::LOCK_OFF_ADDR,
  parameter logic [eeprom_host_pkg::LOCK_MAX-1:0][eeprom_host_pkg::DATA_W-1:0]
    LOCK_OFF_DATA_P = eeprom_host_pkg::LOCK_OFF_DATA
) (
  // Clock and reset
  input  wire logic                                ref_clk_i,
  input  wire logic                                rst_n_i,
  // User request port
  input  wire logic                                req_i,
  input  wire eeprom_host_pkg::op_t                op_i,
  input  wire logic [eeprom_host_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [eeprom_host_pkg::DATA_W-1:0]  wdata_i,
  input  wire logic                                last_i,
  output logic                                     ack_o,
  output logic      [eeprom_host_pkg::DATA_W-1:0]  rdata_o,
  output logic                                     done_o,
  output logic                                     err_o,
  // Memory pins
  output logic      [eeprom_host_pkg::ADDR_W-1:0]  addr_o,
  output logic                                     chip_select_n_o,
  output logic                                     output_drive_n_o,
  output logic                                     write_strobe_n_o,
  output logic                                     high_voltage_o,
  input  wire logic [eeprom_host_pkg::DATA_W-1:0]  data_i,
  output logic      [eeprom_host_pkg::DATA_W-1:0]  data_o,
  output logic                                     data_oe_o
);
  import eeprom_host_pkg::*;

  typedef struct packed {
    state_t              st;
    op_t                 op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wd;
    logic                ce_n;
    logic                oe_n;
    logic                we_n;
    logic                doe;
    logic                hv;
    logic [CNT_W-1:0]    cnt;
    logic [CNT_W-1:0]    tmo;
    logic [11:0]         gap;
    logic [6:0]          page;
    logic                page_ok;
    logic [2:0]          ci;
    logic                in_load;
    logic                closing;
    logic                poll;
    logic                first;
    logic                chk7;
    logic                bit7;
    logic [DATA_W-1:0]   prev;
    logic [DATA_W-1:0]   rdata;
    logic                ack;
    logic                done;
    logic                err;
  } host_st_t;

  host_st_t          q;
  host_st_t          d;
  logic [DATA_W-1:0] data_sync;

  pin_sync #(.W(DATA_W)) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (data_i),
    .sync_o    (data_sync)
  );

  function automatic logic [6:0] page_of(input logic [ADDR_W-1:0] a);
    return a[PAGE_MSB:PAGE_LSB];
  endfunction : page_of

  // Command byte i of a lock sequence as {address, data}
  function automatic logic [ADDR_W+DATA_W-1:0] cmd_word(input op_t op, input logic [2:0] i);
    if (op == OP_LOCK_ON) begin
      return {LOCK_ON_ADDR_P[i], LOCK_ON_DATA_P[i]};
    end
    return {LOCK_OFF_ADDR_P[i], LOCK_OFF_DATA_P[i]};
  endfunction : cmd_word

  function automatic logic [2:0] cmd_len(input op_t op);
    return (op == OP_LOCK_ON) ? 3'(LOCK_ON_LEN) : 3'(LOCK_OFF_LEN);
  endfunction : cmd_len

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d      = q;
    d.ack  = 1'b0;
    d.done = 1'b0;
    d.err  = 1'b0;
    if (q.poll) begin
      d.tmo = q.tmo + 1'b1;
    end
    unique case (q.st)
      S_IDLE: begin
        d.cnt = '0;
        if (req_i) begin
          d.op = op_i;
          unique case (op_i)
            OP_READ: begin
              d.addr = addr_i;
              d.ce_n = 1'b0;
              d.oe_n = 1'b0;
              d.st   = S_RD_WAIT;
            end
            OP_WRITE: begin
              d.addr    = addr_i;
              d.wd      = wdata_i;
              d.page    = page_of(addr_i);
              d.page_ok = 1'b1;
              d.closing = last_i;
              d.chk7    = 1'b1;
              d.bit7    = wdata_i[BUSY_BIT];
              d.ce_n    = 1'b0;
              d.we_n    = 1'b0;
              d.in_load = 1'b1;
              d.st      = S_STRB_LO;
            end
            OP_LOCK_ON, OP_LOCK_OFF: begin
              {d.addr, d.wd} = cmd_word(op_i, 3'h0);
              d.ci      = 3'h0;
              d.page_ok = 1'b0;
              d.closing = last_i;
              d.chk7    = 1'b0;
              d.ce_n    = 1'b0;
              d.we_n    = 1'b0;
              d.in_load = 1'b1;
              d.st      = S_STRB_LO;
            end
            OP_ERASE: begin
              d.ce_n = 1'b0;
              d.hv   = 1'b1;
              d.st   = S_ER_SETUP;
            end
            default: begin
              d.ack = 1'b1;
              d.err = 1'b1;
            end
          endcase
        end else begin
          d.ce_n = 1'b1;
          d.oe_n = 1'b1;
          d.we_n = 1'b1;
        end
      end
      S_STRB_LO: begin
        // Output drive rises only with strobe and select both low
        d.oe_n = 1'b1;
        d.doe  = 1'b1;
        d.cnt  = q.cnt + 1'b1;
        if (q.cnt == WP_CYC - 1'b1) begin
          d.we_n = 1'b1;
          d.cnt  = '0;
          d.st   = S_STRB_HI;
        end
      end
      S_STRB_HI: begin
        d.gap = '0;
        if ((q.op == OP_LOCK_ON || q.op == OP_LOCK_OFF) && q.ci + 3'h1 < cmd_len(q.op)) begin
          d.ci           = q.ci + 3'h1;
          {d.addr, d.wd} = cmd_word(q.op, q.ci + 3'h1);
          d.we_n         = 1'b0;
          d.st           = S_STRB_LO;
        end else begin
          d.ack = 1'b1;
          d.op  = OP_WRITE;
          d.st  = S_LOAD;
        end
      end
      S_LOAD: begin
        d.gap = q.gap + 1'b1;
        if (q.closing || q.gap == LOAD_GUARD - 1'b1) begin
          d.we_n = 1'b0;
          d.doe  = 1'b0;
          d.st   = S_EXIT_LO;
        end else if (req_i && op_i == OP_WRITE &&
                     (!q.page_ok || page_of(addr_i) == q.page)) begin
          d.addr    = addr_i;
          d.wd      = wdata_i;
          d.page    = page_of(addr_i);
          d.page_ok = 1'b1;
          d.closing = last_i;
          d.chk7    = 1'b1;
          d.bit7    = wdata_i[BUSY_BIT];
          d.we_n    = 1'b0;
          d.st      = S_STRB_LO;
        end else if (req_i) begin
          // Other request or new page: finish this load first, request waits
          d.we_n = 1'b0;
          d.doe  = 1'b0;
          d.st   = S_EXIT_LO;
        end
      end
      S_EXIT_LO: begin
        d.oe_n = 1'b0;
        d.st   = S_EXIT_OE;
      end
      S_EXIT_OE: begin
        // Strobe rises with output drive low, so no extra byte is taken
        d.we_n    = 1'b1;
        d.in_load = 1'b0;
        d.poll    = 1'b1;
        d.first   = 1'b1;
        d.tmo     = '0;
        d.cnt     = '0;
        d.st      = S_RD_WAIT;
      end
      S_RD_WAIT: begin
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == READ_CYC - 1'b1) begin
          d.rdata = data_sync;
          d.ce_n  = 1'b1;
          d.oe_n  = 1'b1;
          d.cnt   = '0;
          d.st    = S_RD_REST;
        end
      end
      S_RD_REST: begin
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == OEHP_CYC - 1'b1) begin
          d.cnt = '0;
          if (q.poll) begin
            d.st = S_POLL_CHK;
          end else begin
            d.ack = 1'b1;
            d.st  = S_IDLE;
          end
        end
      end
      S_POLL_CHK: begin
        if (!q.first && q.rdata[TOGGLE_BIT] == q.prev[TOGGLE_BIT] &&
            (!q.chk7 || q.rdata[BUSY_BIT] == q.bit7)) begin
          d.done = 1'b1;
          d.poll = 1'b0;
          d.st   = S_IDLE;
        end else if (q.tmo >= POLL_LIMIT_P) begin
          d.err  = 1'b1;
          d.poll = 1'b0;
          d.st   = S_IDLE;
        end else begin
          d.prev  = q.rdata;
          d.first = 1'b0;
          d.ce_n  = 1'b0;
          d.oe_n  = 1'b0;
          d.st    = S_RD_WAIT;
        end
      end
      S_ER_SETUP: begin
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == ERASE_SH_CYC - 1'b1) begin
          d.we_n = 1'b0;
          d.cnt  = '0;
          d.st   = S_ER_PULSE;
        end
      end
      S_ER_PULSE: begin
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == ERASE_W_P - 1'b1) begin
          d.we_n = 1'b1;
          d.cnt  = '0;
          d.st   = S_ER_HOLD;
        end
      end
      S_ER_HOLD: begin
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == ERASE_SH_CYC - 1'b1) begin
          d.hv   = 1'b0;
          d.ce_n = 1'b1;
          d.ack  = 1'b1;
          d.st   = S_IDLE;
        end
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q      <= '0;
      q.st   <= S_IDLE;
      q.ce_n <= 1'b1;
      q.oe_n <= 1'b1;
      q.we_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign ack_o            = q.ack;
  assign rdata_o          = q.rdata;
  assign done_o           = q.done;
  assign err_o            = q.err;
  assign addr_o           = q.addr;
  assign chip_select_n_o  = q.ce_n;
  assign output_drive_n_o = q.oe_n;
  assign write_strobe_n_o = q.we_n;
  assign high_voltage_o   = q.hv;
  assign data_o           = q.wd;
  assign data_oe_o        = q.doe;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Every strobe fall is a write, a dummy close or an erase pulse, never during a read
  AST_READ_NO_FIGHT: assert property (
    $fell(write_strobe_n_o) |-> output_drive_n_o && !chip_select_n_o)
    else $error("write strobe fell outside write mode");
  AST_READ_FLOAT: assert property (
    !chip_select_n_o && !output_drive_n_o |-> !data_oe_o)
    else $error("host drives data during a read");
  AST_WRITE_DRIVE: assert property (
    data_oe_o |-> !chip_select_n_o && output_drive_n_o && !high_voltage_o)
    else $error("data driven outside write mode");
  AST_STROBE_WIDTH: assert property (
    $fell(write_strobe_n_o) && !high_voltage_o |-> !write_strobe_n_o [*2])
    else $error("write strobe low pulse too short");
  AST_STANDBY_QUIET: assert property (
    chip_select_n_o |-> write_strobe_n_o && !data_oe_o)
    else $error("activity while deselected");
  AST_ERASE_PULSE: assert property (
    $fell(write_strobe_n_o) && high_voltage_o |-> (!chip_select_n_o && !data_oe_o) [*8])
    else $error("erase pulse malformed");
  // Compare with the page held before the strobe, not the one just loaded
  AST_PAGE_SAME: assert property (
    $fell(write_strobe_n_o) && $past(q.st) == S_LOAD && $past(q.page_ok)
      |-> addr_o[PAGE_MSB:PAGE_LSB] == $past(q.page))
    else $error("page select changed within a load");
  AST_OE_IN_LOAD: assert property (
    q.in_load && $changed(output_drive_n_o) |-> !write_strobe_n_o && !chip_select_n_o)
    else $error("output drive moved outside a strobe");
  AST_LOAD_GAP: assert property (
    q.st == S_LOAD |-> q.gap < LOAD_CYC)
    else $error("byte load window overrun");
  AST_BUSY_POLL: assert property (
    q.st == S_POLL_CHK && q.chk7 && q.rdata[BUSY_BIT] != q.bit7 |=> !done_o)
    else $error("completion seen with busy bit set");
  AST_TOGGLE_POLL: assert property (
    q.st == S_POLL_CHK && !q.first && q.rdata[TOGGLE_BIT] != q.prev[TOGGLE_BIT] |=> !done_o)
    else $error("completion seen while bit toggles");

  COV_READ: cover property (q.st == S_RD_REST && !q.poll ##[1:8] ack_o);
  COV_PAGE: cover property (q.st == S_LOAD ##[1:100] $fell(write_strobe_n_o));
  COV_LOCK: cover property (q.op == OP_LOCK_OFF && q.ci == 3'h5);
  COV_ERASE: cover property ($fell(high_voltage_o));
endmodule : eeprom_host

// ===== tb/eeprom_model.sv
// Behavioural page-write memory that stands on the far side of the host
`timescale 1ns/1ns
module eeprom_model
  import eeprom_host_pkg::*;
#(
  parameter int PROG_NS = 10000,
  parameter int LOAD_NS = 150000
) (
  // Memory pins
  input  wire logic [12:0] addr_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        output_drive_n_i,
  input  wire logic        write_strobe_n_i,
  input  wire logic        high_voltage_i,
  input  wire logic [7:0]  data_i,
  output logic      [7:0]  data_o,
  output logic             data_oe_o,
  // Status for the bench
  output logic             locked_o,
  output int               viol_o
);
  logic [7:0]  mem [8192];
  logic [12:0] qa [$];
  logic [7:0]  qd [$];
  logic [12:0] fall_a;
  logic [7:0]  last_d = 8'h00;
  logic        busy = 0;
  logic        tog = 0;
  logic        fell = 0;
  logic        loading = 0;
  realtime     last_t;
  event        go;
  wire wr_n = chip_select_n_i | write_strobe_n_i;
  wire rd_n = chip_select_n_i | output_drive_n_i | ~write_strobe_n_i | high_voltage_i;

  initial begin
    for (int i = 0; i < 8192; i++) mem[i] = i[7:0];
    locked_o = 0;
    viol_o = 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  assign data_oe_o = !rd_n;
  assign data_o = busy ? {~last_d[7], tog, last_d[5:0]} : mem[addr_i];

  task automatic start_prog();
    loading = 0;
    busy = 1;
    -> go;
  endtask : start_prog

  function automatic bit seq(input logic [5:0][12:0] a, input logic [5:0][7:0] d, input int n);
    if (qa.size() < n) return 0;
    for (int k = 0; k < n; k++) if (qa[k] !== a[k] || qd[k] !== d[k]) return 0;
    return 1;
  endfunction : seq

  task automatic commit();
    int   skip = 0;
    logic nxt = locked_o;
    // Longer sequence first: both share their opening bytes
    if (seq(LOCK_OFF_ADDR, LOCK_OFF_DATA, LOCK_OFF_LEN)) begin
      skip = LOCK_OFF_LEN;
      nxt = 0;
    end else if (seq(LOCK_ON_ADDR, LOCK_ON_DATA, LOCK_ON_LEN)) begin
      skip = LOCK_ON_LEN;
      nxt = 1;
    end
    // Protected and unprefixed: timer runs, nothing stored
    if (skip > 0 || !locked_o)
      for (int i = skip; i < qa.size(); i++) mem[qa[i]] = qd[i];
    locked_o = nxt;
    qa.delete();
    qd.delete();
  endtask : commit
  ////////////////////////////////////////////////////////////////////////////
  // A host read ends the byte load early
  always @(negedge rd_n) begin
    if (loading) start_prog();
    else if (busy) tog = ~tog;
  end
  always @(negedge wr_n) begin
    fell = !busy;
    fall_a = addr_i;
    if (high_voltage_i && !busy) for (int i = 0; i < 8192; i++) mem[i] = 8'hff;
  end
  always @(posedge wr_n) begin
    if (fell && output_drive_n_i && !high_voltage_i) begin
      if (loading && qa[0] !== LOCK_ON_ADDR[0] && fall_a[12:6] !== qa[0][12:6]) viol_o++;
      qa.push_back(fall_a);
      qd.push_back(data_i);
      last_d = data_i;
      loading = 1;
      last_t = $realtime;
    end
    fell = 0;
  end
  always @(output_drive_n_i) if (loading && wr_n) viol_o++;
  always begin
    #1000;
    if (loading && $realtime - last_t > LOAD_NS) start_prog();
  end
  always @(go) begin
    #PROG_NS;
    commit();
    busy = 0;
  end
endmodule : eeprom_model

// ===== tb/tb_eeprom_host.sv
// Self-checking bench for the parallel memory host controller
`timescale 1ns/1ns
module tb_eeprom_host;
  import eeprom_host_pkg::*;
  logic        ref_clk_i = 0;
  logic        rst_n_i = 0;
  logic        req_i = 0;
  logic        last_i = 0;
  op_t         op_i = OP_READ;
  logic [12:0] addr_i = 13'h0000;
  logic [7:0]  wdata_i = 8'h00;
  logic [7:0]  bus = 8'h00;
  logic        ack_o, done_o, err_o, high_voltage_o, data_oe_o, dev_oe, locked;
  logic        chip_select_n_o, output_drive_n_o, write_strobe_n_o;
  logic [7:0]  rdata_o, data_o, dev_d;
  logic [12:0] addr_o;
  int          viol;
  int          n_mismatch = 0;
  int          compares = 0;

  always #25 ref_clk_i = ~ref_clk_i;
  // Released bus shows the inverse of its last value
  always @(data_oe_o, data_o, dev_oe, dev_d) begin
    if (data_oe_o) bus = data_o;
    else if (dev_oe) bus = dev_d;
    else bus = ~bus;
  end

  eeprom_host #(.POLL_LIMIT_P(18'h007d0), .ERASE_W_P(18'h00014)) i_eeprom_host (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .op_i(op_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .last_i(last_i), .ack_o(ack_o),
    .rdata_o(rdata_o), .done_o(done_o), .err_o(err_o), .addr_o(addr_o),
    .chip_select_n_o(chip_select_n_o), .output_drive_n_o(output_drive_n_o),
    .write_strobe_n_o(write_strobe_n_o), .high_voltage_o(high_voltage_o),
    .data_i(bus), .data_o(data_o), .data_oe_o(data_oe_o));

  eeprom_model i_eeprom_model (
    .addr_i(addr_o), .chip_select_n_i(chip_select_n_o),
    .output_drive_n_i(output_drive_n_o), .write_strobe_n_i(write_strobe_n_o),
    .high_voltage_i(high_voltage_o), .data_i(bus), .data_o(dev_d),
    .data_oe_o(dev_oe), .locked_o(locked), .viol_o(viol));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("Mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  // Holds the request until acknowledged; returns 5 ns after an edge
  task automatic issue(input op_t op, input logic [12:0] a, input logic [7:0] d,
                       input logic l);
    int n = 0;
    // One edge between requests, so req_i never falls and rises in one step
    @(posedge ref_clk_i);
    #5;
    req_i = 1;
    op_i = op;
    addr_i = a;
    wdata_i = d;
    last_i = l;
    do begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end while (ack_o !== 1'b1 && n < 400);
    #4;
    req_i = 0;
    check({7'h00, ack_o}, 8'h01);
  endtask : issue

  task automatic wait_done();
    int n = 0;
    do begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end while (done_o !== 1'b1 && err_o !== 1'b1 && n < 4000);
    #4;
    check({6'h00, err_o, done_o}, 8'h01);
  endtask : wait_done

  task automatic read_chk(input logic [12:0] a, input logic [7:0] exp);
    issue(OP_READ, a, 8'h00, 1'b1);
    check(rdata_o, exp);
  endtask : read_chk
  ////////////////////////////////////////////////////////////////////////////
  // Two drivers on the data lines never overlap
  always @(negedge ref_clk_i) if (data_oe_o === 1'b1 && dev_oe === 1'b1) check(8'h01, 8'h00);
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_idle();
    check({3'h0, output_drive_n_o, chip_select_n_o, write_strobe_n_o, high_voltage_o,
           data_oe_o}, 8'h1c);
  endtask : t_idle

  // Undefined operation code: refused with an error, pins stay in standby
  task automatic t_bad();
    issue(op_t'(3'h7), 13'h0000, 8'h00, 1'b1);
    check({6'h00, err_o, chip_select_n_o}, 8'h03);
  endtask : t_bad

  task automatic t_byte();
    issue(OP_WRITE, 13'h0045, 8'ha5, 1'b1);
    wait_done();
    read_chk(13'h0045, 8'ha5);
    read_chk(13'h0046, 8'h46);
  endtask : t_byte

  task automatic t_page();
    issue(OP_WRITE, 13'h0081, 8'h11, 1'b0);
    issue(OP_WRITE, 13'h0083, 8'h22, 1'b0);
    issue(OP_WRITE, 13'h0082, 8'h33, 1'b1);
    wait_done();
    read_chk(13'h0081, 8'h11);
    read_chk(13'h0082, 8'h33);
    read_chk(13'h0083, 8'h22);
    read_chk(13'h0084, 8'h84);
  endtask : t_page

  // Load left open: the idle guard must close it
  task automatic t_timeout();
    issue(OP_WRITE, 13'h1234, 8'h5c, 1'b0);
    wait_done();
    read_chk(13'h1234, 8'h5c);
  endtask : t_timeout

  task automatic t_lock();
    issue(OP_LOCK_ON, 13'h0000, 8'h00, 1'b1);
    wait_done();
    check({7'h00, locked}, 8'h01);
    issue(OP_WRITE, 13'h0300, 8'h77, 1'b1);
    wait_done();
    read_chk(13'h0300, 8'h00);
    issue(OP_LOCK_OFF, 13'h0000, 8'h00, 1'b0);
    issue(OP_WRITE, 13'h0301, 8'h9e, 1'b1);
    wait_done();
    check({7'h00, locked}, 8'h00);
    read_chk(13'h0301, 8'h9e);
  endtask : t_lock

  task automatic t_erase();
    issue(OP_ERASE, 13'h0000, 8'h00, 1'b1);
    read_chk(13'h0045, 8'hff);
    read_chk(13'h1fff, 8'hff);
  endtask : t_erase
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(40000 * 50);
    n_mismatch++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge ref_clk_i);
    #5;
    rst_n_i = 1;
    t_idle();
    t_bad();
    t_byte();
    t_page();
    t_timeout();
    t_lock();
    t_erase();
    check(8'(viol), 8'h00);
    stop_test();
  end
endmodule : tb_eeprom_host
